/* sim/cmp_core_model.sv */
// behavioural analog comparator core driving the raw output level
// assumes the bench sets the input difference sign on level_in
module cmp_core_model (
    input wire logic supply_in,
    input wire logic level_in,
    output logic raw_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // unpowered core keeps its last decision, so only the block's gating can pull the pins low
    initial begin
        raw_out = 1'b0;
        forever begin
            @(supply_in or level_in);
            if (supply_in) begin
                raw_out = level_in;
            end
        end
    end
endmodule : cmp_core_model

/* sim/tb_top.sv */
// bench for the comparator control block: axi4-lite register tests and edge flags
// assumes the core model stands in for the analog comparator
module tb_top;
    import cmp_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'b0, rst_b_in = 1'b0, level = 1'b0, raw;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rd_data, rdata;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pwr, raw_o, lat_o, rst_o, kill_o, irq;
    logic [1:0] bresp, rresp, resp, hyp, hyn, md;
    int n_mismatch = 0, cmp_count = 0;
    always #50 sys_clk_in = ~sys_clk_in;
    cmp_core_model i_core (.supply_in(pwr), .level_in(level), .raw_out(raw));
    cmp_ctrl i_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cmp_raw_in(raw), .cmp_power_en_out(pwr), .pos_hysteresis_sel_out(hyp),
        .neg_hysteresis_sel_out(hyn), .response_mode_sel_out(md), .raw_async_output_out(raw_o),
        .latched_sync_output_out(lat_o), .reset_trigger_out(rst_o), .kill_trigger_out(kill_o),
        .irq_out(irq));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // address and data offered together; each released at its own handshake
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        awaddr <= {2'b00, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge sys_clk_in);
    endtask : wr
    task automatic rd(input logic [9:0] a);
        araddr <= {2'b00, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_data = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge sys_clk_in);
    endtask : rd
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic settle();
        repeat (4) @(posedge sys_clk_in);
    endtask : settle
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        rd(CTRL_ADDR);
        chk("ctrl reset", 32'h0000_0000, rd_data);
        rd(MODE_ADDR);
        chk("mode reset", 32'h0000_0002, rd_data);
        chk("mode out reset", 32'(MODE_RESET), 32'(md));
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_ADDR, 32'h80 | (i << HYP_LSB) | (3 - i));
            chk("pos hyst", i, 32'(hyp));
            chk("neg hyst", 3 - i, 32'(hyn));
            chk("power", 32'h1, 32'(pwr));
            rd(CTRL_ADDR);
            chk("ctrl read", 32'h80 | (i << HYP_LSB) | (3 - i), rd_data);
        end
        for (int i = 0; i < 4; i++) begin
            wr(MODE_ADDR, i);
            chk("mode out", i, 32'(md));
        end
        $display("test settings done");
        wr(CTRL_ADDR, 32'h0000_0080);
        level <= 1'b1;
        @(negedge sys_clk_in);
        chk("raw out", 32'h1, 32'(raw_o));
        chk("latched early", 32'h0, 32'(lat_o));
        settle();
        chk("latched", 32'h1, 32'(lat_o));
        chk("reset trig", 32'h1, 32'(rst_o));
        chk("kill trig", 32'h1, 32'(kill_o));
        chk("irq masked", 32'h0, 32'(irq));
        rd(CTRL_ADDR);
        chk("rise flag", 32'h0000_00E0, rd_data);
        wr(MODE_ADDR, 32'h0000_0022);
        chk("irq rise", 32'h1, 32'(irq));
        level <= 1'b0;
        settle();
        rd(CTRL_ADDR);
        chk("both flags", 32'h0000_00B0, rd_data);
        wr(MODE_ADDR, 32'h0000_0012);
        chk("irq fall", 32'h1, 32'(irq));
        wr(CTRL_ADDR, 32'h0000_00A0);
        chk("irq fall cleared", 32'h0, 32'(irq));
        wr(CTRL_ADDR, 32'h0000_0080);
        $display("test edges done");
        level <= 1'b1;
        wr(CTRL_ADDR, 32'h0000_0000);
        settle();
        chk("power off", 32'h0, 32'(pwr));
        chk("raw off", 32'h0, 32'(raw_o));
        chk("latched off", 32'h0, 32'(lat_o));
        $display("test disable done");
        rd(10'h100);
        chk("unmapped rdata", 32'h0, rd_data);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
        wr(10'h100, 32'h0000_00FF);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
        wstrb <= 4'h0;
        wr(CTRL_ADDR, 32'h0000_00BF);
        chk("strobe off bresp", 32'(RESP_OKAY), 32'(resp));
        wstrb <= 4'h1;
        rd(CTRL_ADDR);
        chk("strobe off ignored", 32'h0000_0000, rd_data);
        $display("test unmapped done");
        conclude();
    end
endmodule : tb_top

/* src/cmp_ctrl.sv */
// comparator digital control: enable, edge flags, hysteresis and mode settings, axi4-lite slave
// assumes the analog core supplies cmp_raw_in asynchronously and honours the settings given
module cmp_ctrl
    import cmp_ctrl_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_raw_in,
    output logic cmp_power_en_out,
    output logic [1:0] pos_hysteresis_sel_out,
    output logic [1:0] neg_hysteresis_sel_out,
    output logic [1:0] response_mode_sel_out,
    output logic raw_async_output_out,
    output logic latched_sync_output_out,
    output logic reset_trigger_out,
    output logic kill_trigger_out,
    output logic irq_out
);
    typedef struct packed {
        logic cmp_enable;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
        logic rise_edge_flag;
        logic fall_edge_flag;
        logic rise_irq_enable;
        logic fall_irq_enable;
        logic [1:0] mode;
        logic prev_out;
        logic latched;
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ctrl_s;

    ctrl_s state_reg;
    ctrl_s state_next;
    logic cmp_sync;
    logic gated_sync;
    logic rise_evt;
    logic fall_evt;
    logic do_write;
    logic [7:0] ctrl_rd;
    logic [7:0] mode_rd;

    cmp_sync2 u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .async_in(cmp_raw_in),
        .sync_out(cmp_sync)
    );

    assign gated_sync = cmp_sync & state_reg.cmp_enable;
    assign rise_evt = gated_sync & ~state_reg.prev_out;
    assign fall_evt = ~gated_sync & state_reg.prev_out;

    assign ctrl_rd = {state_reg.cmp_enable, state_reg.latched, state_reg.rise_edge_flag,
                      state_reg.fall_edge_flag, state_reg.pos_hyst, state_reg.neg_hyst};
    assign mode_rd = {2'b00, state_reg.rise_irq_enable, state_reg.fall_irq_enable, 2'b00, state_reg.mode};

    // write fires once both halves are held and the previous response has drained
    assign do_write = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;

    always_comb begin
        state_next = state_reg;
        state_next.prev_out = gated_sync;
        state_next.latched = gated_sync;
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = RESP_OKAY;
            if (state_reg.aw_addr[11:2] == {2'b00, CTRL_IDX}) begin
                if (state_reg.w_strb[0]) begin
                    state_next.cmp_enable = state_reg.w_data[EN_BIT];
                    state_next.pos_hyst = state_reg.w_data[HYP_LSB +: 2];
                    state_next.neg_hyst = state_reg.w_data[HYN_LSB +: 2];
                    state_next.rise_edge_flag = state_reg.w_data[RISE_BIT];
                    state_next.fall_edge_flag = state_reg.w_data[FALL_BIT];
                end
            end else if (state_reg.aw_addr[11:2] == {2'b00, MODE_IDX}) begin
                if (state_reg.w_strb[0]) begin
                    state_next.rise_irq_enable = state_reg.w_data[RIE_BIT];
                    state_next.fall_irq_enable = state_reg.w_data[FIE_BIT];
                    state_next.mode = state_reg.w_data[MD_LSB +: 2];
                end
            end else begin
                state_next.bresp = RESP_SLVERR;
            end
        end
        // hardware set wins over a software clear in the same cycle
        if (rise_evt) begin
            state_next.rise_edge_flag = 1'b1;
        end
        if (fall_evt) begin
            state_next.fall_edge_flag = 1'b1;
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid = 1'b1;
            if (s_axi_araddr[11:2] == {2'b00, CTRL_IDX}) begin
                state_next.rdata = {24'h00_0000, ctrl_rd};
                state_next.rresp = RESP_OKAY;
            end else if (s_axi_araddr[11:2] == {2'b00, MODE_IDX}) begin
                state_next.rdata = {24'h00_0000, mode_rd};
                state_next.rresp = RESP_OKAY;
            end else begin
                state_next.rdata = 32'h0000_0000;
                state_next.rresp = RESP_SLVERR;
            end
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            state_reg <= '0;
            state_reg.mode <= MODE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = ~state_reg.aw_held;
    assign s_axi_wready = ~state_reg.w_held;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = ~state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    assign cmp_power_en_out = state_reg.cmp_enable;
    assign pos_hysteresis_sel_out = state_reg.pos_hyst;
    assign neg_hysteresis_sel_out = state_reg.neg_hyst;
    assign response_mode_sel_out = state_reg.mode;
    // unclocked path so the pin keeps working with the clock stopped
    assign raw_async_output_out = cmp_raw_in & state_reg.cmp_enable;
    assign latched_sync_output_out = state_reg.latched;
    assign reset_trigger_out = state_reg.latched;
    assign kill_trigger_out = state_reg.latched;
    assign irq_out = (state_reg.rise_edge_flag & state_reg.rise_irq_enable)
                   | (state_reg.fall_edge_flag & state_reg.fall_irq_enable);

    property p_rise_sets;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        rise_evt |=> state_reg.rise_edge_flag;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise edge did not set flag");

    property p_fall_sets;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        fall_evt |=> state_reg.fall_edge_flag;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("fall edge did not set flag");

    property p_flag_sticky;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (state_reg.rise_edge_flag && !do_write) |=> state_reg.rise_edge_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("rise flag cleared without write");

    property p_irq_rise;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (irq_out && !state_reg.fall_irq_enable) |-> state_reg.rise_irq_enable;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without any enable");

    property p_irq_fall;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (state_reg.fall_edge_flag && state_reg.fall_irq_enable) |-> irq_out;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("fall flag enabled but no irq");

    property p_disabled_low;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!state_reg.cmp_enable [*2]) |=> !latched_sync_output_out;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("latched output high while off");

    property p_sync_delay;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (state_reg.cmp_enable [*4] ##0 $rose(cmp_raw_in)) ##1 state_reg.cmp_enable [*2]
            |-> !latched_sync_output_out ##1 latched_sync_output_out;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("latched output late");

    property p_mode_reset;
        @(posedge sys_clk_in)
        $rose(rst_b_in) |-> state_reg.mode == MODE_RESET;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not reset to 2");

    property p_fall_sticky;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (state_reg.fall_edge_flag && !do_write) |=> state_reg.fall_edge_flag;
    endproperty
    a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag cleared without write");

    property p_irq_fall_mask;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (irq_out && !state_reg.rise_irq_enable) |-> state_reg.fall_irq_enable;
    endproperty
    a_irq_fall_mask: assert property (p_irq_fall_mask) else $error("irq without fall enable");

    property p_irq_rise_on;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (state_reg.rise_edge_flag && state_reg.rise_irq_enable) |-> irq_out;
    endproperty
    a_irq_rise_on: assert property (p_irq_rise_on) else $error("rise flag enabled but no irq");

    property p_irq_masked;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!state_reg.rise_irq_enable && !state_reg.fall_irq_enable) |-> !irq_out;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with both enables off");

    property p_raw_gated;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        !state_reg.cmp_enable |-> !raw_async_output_out;
    endproperty
    a_raw_gated: assert property (p_raw_gated) else $error("raw output high while off");

    property p_raw_follows;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        state_reg.cmp_enable |-> raw_async_output_out == cmp_raw_in;
    endproperty
    a_raw_follows: assert property (p_raw_follows) else $error("raw output not following core");

    property p_latched_gated;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        latched_sync_output_out |-> $past(state_reg.cmp_enable);
    endproperty
    a_latched_gated: assert property (p_latched_gated) else $error("latched output set while off");

    property p_rise_cause;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        $rose(state_reg.rise_edge_flag) |-> $past(rise_evt) || $past(do_write);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("rise flag set without cause");

    property p_fall_cause;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        $rose(state_reg.fall_edge_flag) |-> $past(fall_evt) || $past(do_write);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("fall flag set without cause");

    property p_ctrl_reset;
        @(posedge sys_clk_in)
        $rose(rst_b_in) |-> (!state_reg.cmp_enable && !state_reg.rise_edge_flag && !state_reg.fall_edge_flag
            && state_reg.pos_hyst == HYST_OFF && state_reg.neg_hyst == HYST_OFF);
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control fields not reset");
endmodule : cmp_ctrl

/* src/cmp_ctrl_pkg.sv */
// constants for the comparator control block: register map, field positions, resets
// assumes a 32-bit axi4-lite register bus; printed offsets are not multiples of four
package cmp_ctrl_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX = 8'h9B;
    localparam logic [7:0] MODE_IDX = 8'h9D;
    localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [9:0] MODE_ADDR = {MODE_IDX, 2'b00};
    // control register fields
    localparam int EN_BIT = 7;
    localparam int OUT_BIT = 6;
    localparam int RISE_BIT = 5;
    localparam int FALL_BIT = 4;
    localparam int HYP_LSB = 2;
    localparam int HYN_LSB = 0;
    // mode register fields
    localparam int RIE_BIT = 5;
    localparam int FIE_BIT = 4;
    localparam int MD_LSB = 0;
    // hysteresis encodings, mode reset value and axi response codes
    localparam logic [1:0] HYST_OFF = 2'h0;
    localparam logic [1:0] HYST_5MV = 2'h1;
    localparam logic [1:0] HYST_10MV = 2'h2;
    localparam logic [1:0] HYST_20MV = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : cmp_ctrl_pkg

/* src/cmp_sync2.sv */
// two-flop synchroniser for the raw comparator level
// assumes the input is asynchronous to sys_clk_in
module cmp_sync2 (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    always_comb begin
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;
endmodule : cmp_sync2
